// *** inc/ocr_pkg.sv ***
// shared constants for the octal clear-enable register block
`default_nettype none
package ocr_pkg;
	localparam int          DATA_W       = 8;
	localparam int          AXI_ADDR_W   = 4;
	localparam int          AXI_DATA_W   = 32;
	localparam int          AXI_STRB_W   = AXI_DATA_W / 8;
	localparam int          LOADS_W      = 16;

	// register byte addresses
	localparam logic [AXI_ADDR_W-1:0] REG_CTRL  = 4'h0;
	localparam logic [AXI_ADDR_W-1:0] REG_STAT  = 4'h4;
	localparam logic [AXI_ADDR_W-1:0] REG_LOADS = 4'h8;

	// control register fields
	localparam int          CTRL_W        = 2;
	localparam int          CTRL_HOLD_BIT = 0;
	localparam int          CTRL_WIPE_BIT = 1;
	localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

	// status register fields
	localparam int          STAT_DRIVE_BIT = 8;
	localparam int          STAT_WIPE_BIT  = 9;
	localparam int          STAT_HOLD_BIT  = 10;

	// reset and clear values
	localparam logic [DATA_W-1:0]  STORE_CLR = 8'h00;
	localparam logic [LOADS_W-1:0] LOADS_RST = 16'h0000;
	localparam logic [LOADS_W-1:0] LOADS_ONE = 16'h0001;
	localparam logic [AXI_DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

	// axi responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** inc/ocr_reg_if.sv ***
// register access carrier between bus slave and register file
`timescale 1ns/1ps
`default_nettype none
interface ocr_reg_if
	import ocr_pkg::*;
();
	logic                    wrEn;
	logic [AXI_ADDR_W-1:0]   wrAddr;
	logic [AXI_DATA_W-1:0]   wrData;
	logic [AXI_STRB_W-1:0]   wrStrb;
	logic                    wrErr;
	logic [AXI_ADDR_W-1:0]   rdAddr;
	logic [AXI_DATA_W-1:0]   rdData;
	logic                    rdErr;

	modport slv (
		output wrEn,
		output wrAddr,
		output wrData,
		output wrStrb,
		output rdAddr,
		input  wrErr,
		input  rdData,
		input  rdErr
	);

	modport regs (
		input  wrEn,
		input  wrAddr,
		input  wrData,
		input  wrStrb,
		input  rdAddr,
		output wrErr,
		output rdData,
		output rdErr
	);
endinterface // ocr_reg_if
`default_nettype wire

// *** core/ocr_axil_slave.sv ***
// axi4-lite slave front end for the register file
`timescale 1ns/1ps
`default_nettype none
module ocr_axil_slave
	import ocr_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic [AXI_ADDR_W-1:0] s_axil_awaddr,
	input  wire logic                  s_axil_awvalid,
	output var  logic                  s_axil_awready,
	input  wire logic [AXI_DATA_W-1:0] s_axil_wdata,
	input  wire logic [AXI_STRB_W-1:0] s_axil_wstrb,
	input  wire logic                  s_axil_wvalid,
	output var  logic                  s_axil_wready,
	output var  logic [1:0]            s_axil_bresp,
	output var  logic                  s_axil_bvalid,
	input  wire logic                  s_axil_bready,
	input  wire logic [AXI_ADDR_W-1:0] s_axil_araddr,
	input  wire logic                  s_axil_arvalid,
	output var  logic                  s_axil_arready,
	output var  logic [AXI_DATA_W-1:0] s_axil_rdata,
	output var  logic [1:0]            s_axil_rresp,
	output var  logic                  s_axil_rvalid,
	input  wire logic                  s_axil_rready,
	ocr_reg_if.slv                     regs
);
	logic                  awHeld_q;
	logic                  wHeld_q;
	logic [AXI_ADDR_W-1:0] awAddr_q;
	logic [AXI_DATA_W-1:0] wData_q;
	logic [AXI_STRB_W-1:0] wStrb_q;
	wire                   awHs    = s_axil_awvalid & s_axil_awready;
	wire                   wHs     = s_axil_wvalid & s_axil_wready;
	wire                   bHs     = s_axil_bvalid & s_axil_bready;
	wire                   arHs    = s_axil_arvalid & s_axil_arready;
	wire                   rHs     = s_axil_rvalid & s_axil_rready;
	wire                   doWrite = awHeld_q & wHeld_q & ~s_axil_bvalid;

	assign regs.wrEn   = doWrite;
	assign regs.wrAddr = awAddr_q;
	assign regs.wrData = wData_q;
	assign regs.wrStrb = wStrb_q;
	assign regs.rdAddr = s_axil_araddr;

	// write address and data, in either order
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axil_awready <= 1'b0;
			s_axil_wready  <= 1'b0;
			awHeld_q       <= 1'b0;
			wHeld_q        <= 1'b0;
			awAddr_q       <= '0;
			wData_q        <= WORD_ZERO;
			wStrb_q        <= '0;
		end else begin
			s_axil_awready <= ~awHs & ~awHeld_q & ~s_axil_bvalid;
			s_axil_wready  <= ~wHs & ~wHeld_q & ~s_axil_bvalid;
			awHeld_q       <= ~doWrite & (awHeld_q | awHs);
			wHeld_q        <= ~doWrite & (wHeld_q | wHs);
			if (awHs) awAddr_q <= s_axil_awaddr;
			if (wHs) wData_q <= s_axil_wdata;
			if (wHs) wStrb_q <= s_axil_wstrb;
		end
	end

	// write response
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axil_bvalid <= 1'b0;
			s_axil_bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			s_axil_bvalid <= 1'b1;
			s_axil_bresp  <= regs.wrErr ? RESP_SLVERR : RESP_OKAY;
		end else if (bHs) begin
			s_axil_bvalid <= 1'b0;
		end
	end

	// read channel, answer one cycle after the address
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axil_arready <= 1'b0;
			s_axil_rvalid  <= 1'b0;
			s_axil_rdata   <= WORD_ZERO;
			s_axil_rresp   <= RESP_OKAY;
		end else begin
			s_axil_arready <= ~arHs & ~s_axil_rvalid;
			if (arHs) begin
				s_axil_rvalid <= 1'b1;
				s_axil_rdata  <= regs.rdData;
				s_axil_rresp  <= regs.rdErr ? RESP_SLVERR : RESP_OKAY;
			end else if (rHs) begin
				s_axil_rvalid <= 1'b0;
			end
		end
	end
endmodule // ocr_axil_slave
`default_nettype wire

// *** core/ocr_top.sv ***
// octal register with clear, load gate and gated drive enable
`timescale 1ns/1ps
`default_nettype none
module ocr_top
	import ocr_pkg::*;
#(
	parameter int WIDTH = DATA_W
)
(
	input  wire logic                  clk,
	input  wire logic                  nrst,

	input  wire logic [AXI_ADDR_W-1:0] s_axil_awaddr,
	input  wire logic [2:0]            s_axil_awprot,
	input  wire logic                  s_axil_awvalid,
	output var  logic                  s_axil_awready,
	input  wire logic [AXI_DATA_W-1:0] s_axil_wdata,
	input  wire logic [AXI_STRB_W-1:0] s_axil_wstrb,
	input  wire logic                  s_axil_wvalid,
	output var  logic                  s_axil_wready,
	output var  logic [1:0]            s_axil_bresp,
	output var  logic                  s_axil_bvalid,
	input  wire logic                  s_axil_bready,
	input  wire logic [AXI_ADDR_W-1:0] s_axil_araddr,
	input  wire logic [2:0]            s_axil_arprot,
	input  wire logic                  s_axil_arvalid,
	output var  logic                  s_axil_arready,
	output var  logic [AXI_DATA_W-1:0] s_axil_rdata,
	output var  logic [1:0]            s_axil_rresp,
	output var  logic                  s_axil_rvalid,
	input  wire logic                  s_axil_rready,

	input  wire logic                  shared_clock,
	input  wire logic [WIDTH-1:0]      data_in,
	input  wire logic                  loadGate_n,
	input  wire logic                  wipe_n,
	input  wire logic                  out_drive_a_n,
	input  wire logic                  out_drive_b_n,
	input  wire logic                  out_drive_c_n,
	output var  logic [WIDTH-1:0]      dataOut,
	output var  logic                  dataOutEn
);

	// register map helpers
	function automatic logic regMapped(input logic [AXI_ADDR_W-1:0] addr);
		return (addr == REG_CTRL) || (addr == REG_STAT) ||
			(addr == REG_LOADS);
	endfunction

	ocr_reg_if regIf ();

	// storage and control state
	logic [WIDTH-1:0]   storage_q;
	logic [WIDTH-1:0]   storage_d;
	logic               clkPrev_q;
	logic               driveEn_q;
	logic [CTRL_W-1:0]  ctrl_q;
	logic [CTRL_W-1:0]  ctrl_d;
	logic [LOADS_W-1:0] loads_q;
	logic [LOADS_W-1:0] loads_d;

	// pin decode
	wire               clkRise  = shared_clock & ~clkPrev_q;
	wire               wipeAct  = ~wipe_n | ctrl_q[CTRL_WIPE_BIT];
	wire               holdAct  = loadGate_n | ctrl_q[CTRL_HOLD_BIT];
	wire               doLoad   = clkRise & ~holdAct & ~wipeAct;
	wire [2:0]         oeBits   = {out_drive_c_n, out_drive_b_n,
		out_drive_a_n};
	wire               allLow   = ~|oeBits;

	// register write decode
	wire               wrCtrl   = regIf.wrEn & regIf.wrStrb[0] &
		(regIf.wrAddr == REG_CTRL);
	wire               wrLoads  = regIf.wrEn & regIf.wrStrb[0] &
		(regIf.wrAddr == REG_LOADS);

	// register read selection
	wire [AXI_DATA_W-1:0] ctrlWord = {{(AXI_DATA_W-CTRL_W){1'b0}}, ctrl_q};
	wire [AXI_DATA_W-1:0] statStore = AXI_DATA_W'(storage_q);
	wire [AXI_DATA_W-1:0] statDrive =
		AXI_DATA_W'(driveEn_q) << STAT_DRIVE_BIT;
	wire [AXI_DATA_W-1:0] statWipe  =
		AXI_DATA_W'(wipeAct) << STAT_WIPE_BIT;
	wire [AXI_DATA_W-1:0] statHold  =
		AXI_DATA_W'(holdAct) << STAT_HOLD_BIT;
	wire [AXI_DATA_W-1:0] statWord  =
		statStore | statDrive | statWipe | statHold;
	wire [AXI_DATA_W-1:0] loadWord = {{(AXI_DATA_W-LOADS_W){1'b0}}, loads_q};

	assign regIf.wrErr  = ~regMapped(regIf.wrAddr);
	assign regIf.rdErr  = ~regMapped(regIf.rdAddr);
	assign regIf.rdData = (regIf.rdAddr == REG_CTRL)  ? ctrlWord :
		(regIf.rdAddr == REG_STAT)  ? statWord :
		(regIf.rdAddr == REG_LOADS) ? loadWord : WORD_ZERO;

	// next values
	assign ctrl_d    = wrCtrl ? regIf.wrData[CTRL_W-1:0] : ctrl_q;
	assign storage_d = wipeAct ? STORE_CLR :
		doLoad ? data_in : storage_q;
	assign loads_d   = doLoad ? loads_q + LOADS_ONE :
		wrLoads ? LOADS_RST : loads_q;

	// all bits share one edge detector and one load decision
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			storage_q <= STORE_CLR;
			clkPrev_q <= 1'b0;
		end else begin
			storage_q <= storage_d;
			clkPrev_q <= shared_clock;
		end
	end

	// drive enable, set only when every enable is low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			driveEn_q <= 1'b0;
		end else begin
			driveEn_q <= allLow;
		end
	end

	// software control and load count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q  <= CTRL_RST;
			loads_q <= LOADS_RST;
		end else begin
			ctrl_q  <= ctrl_d;
			loads_q <= loads_d;
		end
	end

	// outputs: stored bits as is, plus separate drive enable
	assign dataOut   = storage_q;
	assign dataOutEn = driveEn_q;

	ocr_axil_slave u_slave (
		.clk            (clk),
		.nrst           (nrst),
		.s_axil_awaddr  (s_axil_awaddr),
		.s_axil_awvalid (s_axil_awvalid),
		.s_axil_awready (s_axil_awready),
		.s_axil_wdata   (s_axil_wdata),
		.s_axil_wstrb   (s_axil_wstrb),
		.s_axil_wvalid  (s_axil_wvalid),
		.s_axil_wready  (s_axil_wready),
		.s_axil_bresp   (s_axil_bresp),
		.s_axil_bvalid  (s_axil_bvalid),
		.s_axil_bready  (s_axil_bready),
		.s_axil_araddr  (s_axil_araddr),
		.s_axil_arvalid (s_axil_arvalid),
		.s_axil_arready (s_axil_arready),
		.s_axil_rdata   (s_axil_rdata),
		.s_axil_rresp   (s_axil_rresp),
		.s_axil_rvalid  (s_axil_rvalid),
		.s_axil_rready  (s_axil_rready),
		.regs           (regIf.slv)
	);

	// checks
	default clocking cb @(posedge clk);
	endclocking

	default disable iff (!nrst);

	sequence s_load;
		clkRise && !holdAct && !wipeAct;
	endsequence

	sequence s_wipeOpen;
		wipeAct && allLow;
	endsequence

	sequence s_zeroDriven;
		(dataOut == STORE_CLR) && dataOutEn;
	endsequence

	sequence s_oeToggle;
		$changed(oeBits) && !wipeAct && !(clkRise && !holdAct);
	endsequence

	sequence s_gateShut;
		holdAct && !wipeAct;
	endsequence

	property p_bitCapture;
		s_load |=> (storage_q ^ $past(data_in)) == STORE_CLR;
	endproperty
	a_bitCapture: assert property (p_bitCapture)
		else $error("stored bits differ from captured inputs");

	property p_edgeOnly;
		!clkRise && !wipeAct |=> storage_q == $past(storage_q);
	endproperty
	a_edgeOnly: assert property (p_edgeOnly)
		else $error("storage changed without a shared clock rise");

	property p_load;
		s_load ##1 (!wipeAct && !clkRise)
			|-> ##1 storage_q == $past(data_in, 2);
	endproperty
	a_load: assert property (p_load)
		else $error("load on clock rise lost");

	property p_hold;
		holdAct && !wipeAct |=> $stable(storage_q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("stored value changed while gated");

	property p_noLoadInWipe;
		wipeAct && clkRise && !holdAct |=> storage_q == STORE_CLR;
	endproperty
	a_noLoadInWipe: assert property (p_noLoadInWipe)
		else $error("load taken while clear active");

	property p_wipeRead;
		s_wipeOpen ##1 s_wipeOpen |-> s_zeroDriven;
	endproperty
	a_wipeRead: assert property (p_wipeRead)
		else $error("outputs not driven low during clear");

	property p_drive;
		allLow |=> dataOutEn;
	endproperty
	a_drive: assert property (p_drive)
		else $error("outputs not driven with all enables low");

	property p_hiZ;
		!allLow |=> !dataOutEn;
	endproperty
	a_hiZ: assert property (p_hiZ)
		else $error("outputs driven with an enable high");

	property p_oeNoEffect;
		s_oeToggle |=> $stable(storage_q);
	endproperty
	a_oeNoEffect: assert property (p_oeNoEffect)
		else $error("enable change disturbed storage");

	property p_polarity;
		s_load |=> dataOut == $past(data_in);
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("output does not follow loaded data");

	property p_enableCause;
		$rose(dataOutEn) |-> $past(allLow);
	endproperty
	a_enableCause: assert property (p_enableCause)
		else $error("drive enable rose without all enables low");

	property p_loadThenHold;
		s_load ##1 s_gateShut |-> ##1 storage_q == $past(data_in, 2);
	endproperty
	a_loadThenHold: assert property (p_loadThenHold)
		else $error("gated value lost after a load");

	property p_gateBlock;
		loadGate_n && clkRise && !wipeAct |=> $stable(storage_q);
	endproperty
	a_gateBlock: assert property (p_gateBlock)
		else $error("clock rise loaded while gate high");

	property p_softHold;
		ctrl_q[CTRL_HOLD_BIT] && !wipeAct |=> $stable(storage_q);
	endproperty
	a_softHold: assert property (p_softHold)
		else $error("software hold did not keep the value");

	property p_pinWipe;
		!wipe_n |=> storage_q == STORE_CLR;
	endproperty
	a_pinWipe: assert property (p_pinWipe)
		else $error("clear pin did not empty the store");

	property p_softWipe;
		ctrl_q[CTRL_WIPE_BIT] |=> storage_q == STORE_CLR;
	endproperty
	a_softWipe: assert property (p_softWipe)
		else $error("software clear did not empty the store");

	property p_enableDrop;
		$fell(dataOutEn) |-> !$past(allLow);
	endproperty
	a_enableDrop: assert property (p_enableDrop)
		else $error("drive enable fell with all enables low");

	property p_idleWhileOff;
		!dataOutEn && !wipeAct && !doLoad |=> $stable(storage_q);
	endproperty
	a_idleWhileOff: assert property (p_idleWhileOff)
		else $error("storage moved while outputs released");

	property p_countLoad;
		doLoad |=> loads_q == $past(loads_q) + LOADS_ONE;
	endproperty
	a_countLoad: assert property (p_countLoad)
		else $error("load count missed a load");

	property p_countZero;
		wrLoads && !doLoad |=> loads_q == LOADS_RST;
	endproperty
	a_countZero: assert property (p_countZero)
		else $error("load count not zeroed by write");

	property p_countKeep;
		!doLoad && !wrLoads |=> $stable(loads_q);
	endproperty
	a_countKeep: assert property (p_countKeep)
		else $error("load count moved without a load");

	property p_wipeNoCount;
		wipeAct && !wrLoads |=> $stable(loads_q);
	endproperty
	a_wipeNoCount: assert property (p_wipeNoCount)
		else $error("load counted while clear active");

	property p_gateNoCount;
		holdAct && !wrLoads |=> $stable(loads_q);
	endproperty
	a_gateNoCount: assert property (p_gateNoCount)
		else $error("load counted while gated");

	property p_ctrlWrite;
		wrCtrl |=> ctrl_q == $past(regIf.wrData[CTRL_W-1:0]);
	endproperty
	a_ctrlWrite: assert property (p_ctrlWrite)
		else $error("control write not taken");

	property p_ctrlKeep;
		!wrCtrl |=> $stable(ctrl_q);
	endproperty
	a_ctrlKeep: assert property (p_ctrlKeep)
		else $error("control changed without a write");

endmodule // ocr_top
`default_nettype wire

// *** verif/ocr_bus_model.sv ***
// downstream bus model resolving the drive enable into bus levels
`timescale 1ns/1ps
`default_nettype none
module ocr_bus_model
	import ocr_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [DATA_W-1:0] dataOut,
	input  wire logic              dataOutEn,
	output var  logic [DATA_W-1:0] busVal
);
	logic [DATA_W-1:0] lastQ = STORE_CLR;

	// released bus, no pull: shows the inverse of the last driven value
	always @(posedge clk) begin
		if (dataOutEn) lastQ <= dataOut;
	end
	assign busVal = dataOutEn ? dataOut : ~lastQ;
endmodule // ocr_bus_model
`default_nettype wire

// *** verif/tb_ocr_top.sv ***
// self-checking bench for the octal register block
`timescale 1ns/1ps
`default_nettype none
module tb_ocr_top
	import ocr_pkg::*;
;
	logic                  clk, nrst;
	logic [AXI_ADDR_W-1:0] awaddr, araddr;
	logic [AXI_DATA_W-1:0] wdata, rdata;
	logic [AXI_STRB_W-1:0] wstrb;
	logic [1:0]            bresp, rresp;
	logic                  awvalid, awready, wvalid, wready, bvalid, bready;
	logic                  arvalid, arready, rvalid, rready;
	logic                  sc, gateN, wipeN, oeA, oeB, oeC, look, dEn;
	logic [DATA_W-1:0]     din, dOut, busVal, d, e;
	logic [35:0]           q[$];
	int                    badCount, testsRun, cnt;

	ocr_top i_ocr_top (.clk(clk), .nrst(nrst),
		.s_axil_awaddr(awaddr), .s_axil_awprot(3'h0),
		.s_axil_awvalid(awvalid), .s_axil_awready(awready),
		.s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
		.s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
		.s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arprot(3'h0),
		.s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
		.s_axil_rready(rready), .shared_clock(sc), .data_in(din),
		.loadGate_n(gateN), .wipe_n(wipeN), .out_drive_a_n(oeA),
		.out_drive_b_n(oeB), .out_drive_c_n(oeC), .dataOut(dOut),
		.dataOutEn(dEn));
	ocr_bus_model i_ocr_bus_model (.clk(clk), .dataOut(dOut),
		.dataOutEn(dEn), .busVal(busVal));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic cmp(input logic [1:0] kind, input logic [33:0] got);
		logic [35:0] x;
		x = (q.size() > 0) ? q.pop_front() : 36'hf_ffff_ffff;
		testsRun++;
		if (x[35:34] !== kind || got !== x[33:0]) begin
			badCount++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, x[33:0], got);
		end
	endtask

	// result monitor
	always @(posedge clk) begin
		if (rvalid && rready) cmp(2'h1, {rresp, rdata});
		if (bvalid && bready) cmp(2'h2, {bresp, WORD_ZERO});
		if (look) cmp(2'h0, {17'h0, dOut, dEn, busVal});
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] v,
		input logic [1:0] r);
		q.push_back({2'h2, r, WORD_ZERO});
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] v,
		input logic [1:0] r);
		q.push_back({2'h1, r, v});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic pulse(input logic [7:0] v);
		din <= v;
		sc <= 1'b1;
		@(posedge clk);
		sc <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk(input logic en, input logic [7:0] v);
		q.push_back({2'h0, 17'h0, v, en, en ? v : ~v});
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
		@(posedge clk);
	endtask

	task automatic oe(input logic [2:0] k);
		oeA <= k[0];
		oeB <= k[1];
		oeC <= k[2];
		@(posedge clk);
	endtask

	initial begin
		#200000;
		badCount++;
		complete_run();
	end

	initial begin
		nrst = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready, sc, look} = '0;
		{gateN, wipeN, oeA, oeB, oeC} = 5'h1f;
		din = STORE_CLR;
		badCount = 0;
		testsRun = 0;
		cnt = 0;
		void'($urandom(14));
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(REG_CTRL, WORD_ZERO, RESP_OKAY);
		rd(REG_LOADS, WORD_ZERO, RESP_OKAY);
		rd(4'hc, WORD_ZERO, RESP_SLVERR);
		wr(4'hc, 32'hffff_ffff, RESP_SLVERR);
		chk(1'b0, STORE_CLR);
		gateN <= 1'b0;
		oe(3'h0);
		chk(1'b1, STORE_CLR);
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom);
			pulse(d);
			cnt++;
			chk(1'b1, d);
		end
		wr(REG_STAT, WORD_ZERO, RESP_OKAY);
		rd(REG_STAT, {21'h0, 3'h1, d}, RESP_OKAY);
		gateN <= 1'b1;
		pulse(~d);
		chk(1'b1, d);
		gateN <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			oe(3'(k));
			chk(k == 0, d);
		end
		e = 8'($urandom);
		pulse(e);
		cnt++;
		oe(3'h0);
		chk(1'b1, e);
		wipeN <= 1'b0;
		pulse(8'hff);
		chk(1'b1, STORE_CLR);
		wipeN <= 1'b1;
		pulse(8'h3c);
		cnt++;
		chk(1'b1, 8'h3c);
		wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
		pulse(8'hc3);
		chk(1'b1, 8'h3c);
		rd(REG_STAT, {21'h0, 3'h5, 8'h3c}, RESP_OKAY);
		wr(REG_CTRL, 32'h0000_0002, RESP_OKAY);
		chk(1'b1, STORE_CLR);
		rd(REG_STAT, {21'h0, 3'h3, STORE_CLR}, RESP_OKAY);
		wr(REG_CTRL, WORD_ZERO, RESP_OKAY);
		rd(REG_LOADS, {16'h0, 16'(cnt)}, RESP_OKAY);
		wr(REG_LOADS, WORD_ZERO, RESP_OKAY);
		rd(REG_LOADS, WORD_ZERO, RESP_OKAY);
		complete_run();
	end
endmodule // tb_ocr_top
`default_nettype wire
